// file: pkg/sdt_pkg.sv
// constants and types of the stabilized differential trip logic
package sdt_pkg;
    // -------------------------------------------------------------------
    // widths and scaling
    // -------------------------------------------------------------------
    localparam int  CUR_W        = 16;
    localparam int  RATIO_W      = 8;
    localparam int  N_PHASE      = 3;
    localparam int  N_CHAN       = 6;
    localparam int  N_DIG        = 16;
    localparam int  RATED_UNIT   = 256;
    localparam int  INST_MIN_X   = 5;
    localparam int  INST_MAX_X   = 30;
    localparam logic [CUR_W-1:0] INST_MIN = CUR_W'(INST_MIN_X * RATED_UNIT);
    localparam logic [CUR_W-1:0] INST_MAX = CUR_W'(INST_MAX_X * RATED_UNIT);
    // -------------------------------------------------------------------
    // recording length
    // -------------------------------------------------------------------
    localparam int  REC_CYCLES   = 38;
    localparam int  REC_SPC      = 40;
    localparam int  REC_DEPTH    = REC_CYCLES * REC_SPC;
    localparam int  REC_AW       = $clog2(REC_DEPTH);
    // -------------------------------------------------------------------
    // recorder states
    // -------------------------------------------------------------------
    typedef enum logic [2:0] {
        SDT_REC_IDLE = 3'b001,
        SDT_REC_RUN  = 3'b010,
        SDT_REC_HELD = 3'b100
    } sdt_rec_state_t;
endpackage : sdt_pkg

// file: rtl/sdt_phase.sv
// one phase of the differential decision
`timescale 1ns/1ps
module sdt_phase #(
    parameter int CW = sdt_pkg::CUR_W,
    parameter int RW = sdt_pkg::RATIO_W
) (
    input  wire logic [CW-1:0] id_fund,
    input  wire logic [CW-1:0] id_inst,
    input  wire logic [CW-1:0] i_stab,
    input  wire logic [RW-1:0] second_harmonic_ratio,
    input  wire logic [RW-1:0] fifth_harmonic_ratio,
    input  wire logic          internal_fault_hint,
    input  wire logic [CW-1:0] base_level,
    input  wire logic [RW-1:0] slope,
    input  wire logic [RW-1:0] second_limit,
    input  wire logic [RW-1:0] fifth_limit,
    input  wire logic [RW-1:0] overexcitation_unblock_limit,
    input  wire logic          harm_block_disable,
    input  wire logic [CW-1:0] inst_limit,
    output logic               stab_trip,
    output logic               inst_trip,
    output logic               block2,
    output logic               block5
);
    logic [CW+RW:0] stab_thr;
    logic [CW+1:0]  inst_thr_fund;
    logic [CW+1:0]  inst_thr_samp;
    logic           low_stab;
    logic [CW+3:0]  stab_x10;
    logic [CW+3:0]  id_x3;

    always_comb begin
        // stabilizing < 0.3 * differential  <=>  10*stab < 3*id
        stab_x10 = (CW+4)'(i_stab) * (CW+4)'(10);
        id_x3    = (CW+4)'(id_fund) * (CW+4)'(3);
        low_stab = stab_x10 < id_x3;
        // threshold = base + stab*slope/256, grows with load current
        stab_thr = (CW+RW+1)'(base_level) + (CW+RW+1)'(((CW+RW+1)'(i_stab) * (CW+RW+1)'(slope)) >> 8);
        block2   = !harm_block_disable && !low_stab && !internal_fault_hint
                   && (second_harmonic_ratio > second_limit);
        block5   = !harm_block_disable && !low_stab
                   && (fifth_harmonic_ratio > fifth_limit)
                   && (fifth_harmonic_ratio < overexcitation_unblock_limit);
        stab_trip = ((CW+RW+1)'(id_fund) > stab_thr) && !block2 && !block5;
        inst_thr_fund = low_stab ? (CW+2)'(inst_limit >> 1) : (CW+2)'(inst_limit);
        // 2.5 x limit, halved together with the fundamental limit
        inst_thr_samp = (CW+2)'((((CW+2)'(inst_limit) << 2) + (CW+2)'(inst_limit)) >> 1);
        if (low_stab) begin
            inst_thr_samp = inst_thr_samp >> 1;
        end
        inst_trip = ((CW+2)'(id_fund) > inst_thr_fund)
                    || ((CW+2)'(id_inst) > inst_thr_samp);
    end
endmodule : sdt_phase

// file: rtl/sdt_recorder.sv
// single-shot disturbance recorder
`timescale 1ns/1ps
module sdt_recorder #(
    parameter int CW    = sdt_pkg::CUR_W,
    parameter int ND    = sdt_pkg::N_DIG,
    parameter int DEPTH = sdt_pkg::REC_DEPTH,
    parameter int AW    = sdt_pkg::REC_AW
) (
    input  wire logic                   sys_clk,
    input  wire logic                   rstn,
    input  wire logic                   clk_en,
    input  wire logic                   sample_tick,
    input  wire logic [6*CW-1:0]        chan_in,
    input  wire logic [ND-1:0]          dig_in,
    input  wire logic [ND-1:0]          trig_sel,
    input  wire logic [ND-1:0]          trig_falling,
    input  wire logic                   rec_clear,
    input  wire logic [AW-1:0]          rd_addr,
    output logic [6*CW-1:0]             rd_chan,
    output logic [ND-1:0]               rd_dig,
    output logic                        rec_busy,
    output logic                        rec_held
);
    sdt_pkg::sdt_rec_state_t state_reg;
    logic [6*CW-1:0] chan_mem [DEPTH];
    logic [ND-1:0]   dig_mem  [DEPTH];
    logic [ND-1:0]   dig_prev_reg;
    logic            prev_ok_reg;
    logic [AW-1:0]   wr_idx_reg;
    logic            trig;
    logic            wr_en;

    always_comb begin
        trig  = prev_ok_reg && |(trig_sel & ((trig_falling & dig_prev_reg & ~dig_in)
                                           | (~trig_falling & ~dig_prev_reg & dig_in)));
        wr_en = (state_reg == sdt_pkg::SDT_REC_RUN) && sample_tick;
    end

    // polarity per bit; no edge before a first sample is held, so a level high out of reset is no edge
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            dig_prev_reg <= '0;
            prev_ok_reg  <= 1'b0;
        end else if (clk_en && sample_tick) begin
            dig_prev_reg <= dig_in;
            prev_ok_reg  <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg  <= sdt_pkg::SDT_REC_IDLE;
            wr_idx_reg <= '0;
        end else if (clk_en) begin
            unique case (state_reg)
                sdt_pkg::SDT_REC_IDLE: begin
                    if (sample_tick && trig) begin
                        state_reg  <= sdt_pkg::SDT_REC_RUN;
                        wr_idx_reg <= '0;
                    end
                end
                sdt_pkg::SDT_REC_RUN: begin
                    if (sample_tick) begin
                        if (wr_idx_reg == AW'(DEPTH-1)) begin
                            state_reg <= sdt_pkg::SDT_REC_HELD;
                        end else begin
                            wr_idx_reg <= wr_idx_reg + 1'b1;
                        end
                    end
                end
                sdt_pkg::SDT_REC_HELD: begin
                    if (rec_clear) begin
                        state_reg <= sdt_pkg::SDT_REC_IDLE;
                    end
                end
                default: state_reg <= sdt_pkg::SDT_REC_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (clk_en && wr_en) begin
            chan_mem[wr_idx_reg] <= chan_in;
            dig_mem[wr_idx_reg]  <= dig_in;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rd_chan  <= '0;
            rd_dig   <= '0;
            rec_busy <= 1'b0;
            rec_held <= 1'b0;
        end else if (clk_en) begin
            rd_chan  <= chan_mem[rd_addr];
            rd_dig   <= dig_mem[rd_addr];
            rec_busy <= state_reg == sdt_pkg::SDT_REC_RUN;
            rec_held <= state_reg == sdt_pkg::SDT_REC_HELD;
        end
    end

    AST_HELD_STABLE: assert property (@(posedge sys_clk) disable iff (!rstn)
        (state_reg == sdt_pkg::SDT_REC_HELD) && !rec_clear |=> state_reg == sdt_pkg::SDT_REC_HELD)
        else $error("held recording lost without clear");
    AST_NO_WRITE_HELD: assert property (@(posedge sys_clk) disable iff (!rstn)
        (state_reg == sdt_pkg::SDT_REC_HELD) |-> !wr_en)
        else $error("write while recording held");
    AST_LEN: assert property (@(posedge sys_clk) disable iff (!rstn)
        (state_reg == sdt_pkg::SDT_REC_RUN) |-> wr_idx_reg <= AW'(DEPTH-1))
        else $error("recording index beyond length");
    AST_TRIG_START: assert property (@(posedge sys_clk) disable iff (!rstn)
        clk_en && (state_reg == sdt_pkg::SDT_REC_IDLE) && sample_tick && trig
        |=> state_reg == sdt_pkg::SDT_REC_RUN && wr_idx_reg == '0)
        else $error("trigger did not start recording");
endmodule : sdt_recorder

// file: rtl/sdt_top.sv
// top of the stabilized differential trip logic
`timescale 1ns/1ps
module sdt_top #(
    parameter int CW = sdt_pkg::CUR_W,
    parameter int RW = sdt_pkg::RATIO_W,
    parameter int ND = sdt_pkg::N_DIG,
    parameter int AW = sdt_pkg::REC_AW
) (
    input  wire logic                  sys_clk,
    input  wire logic                  rstn,
    input  wire logic                  clk_en,
    input  wire logic                  sample_tick,
    input  wire logic [3*CW-1:0]       hv_fund,
    input  wire logic [3*CW-1:0]       lv_fund,
    input  wire logic [3*CW-1:0]       hv_inst,
    input  wire logic [3*CW-1:0]       lv_inst,
    input  wire logic [3*RW-1:0]       second_harmonic_ratio,
    input  wire logic [3*RW-1:0]       fifth_harmonic_ratio,
    input  wire logic [2:0]            internal_fault_hint,
    input  wire logic [RW-1:0]         hv_ratio_corr,
    input  wire logic [RW-1:0]         lv_ratio_corr,
    input  wire logic                  hv_match_en,
    input  wire logic                  lv_match_en,
    input  wire logic [CW-1:0]         base_level,
    input  wire logic [RW-1:0]         slope,
    input  wire logic [RW-1:0]         second_limit,
    input  wire logic [RW-1:0]         fifth_limit,
    input  wire logic [RW-1:0]         overexcitation_unblock_limit,
    input  wire logic                  harm_block_disable,
    input  wire logic [CW-1:0]         instantaneous_operate_limit,
    input  wire logic [4:0]            control_in,
    input  wire logic [ND-1:0]         trig_sel,
    input  wire logic [ND-1:0]         trig_falling,
    input  wire logic                  rec_clear,
    input  wire logic [AW-1:0]         rd_addr,
    output logic                       operate,
    output logic [2:0]                 phase_operate,
    output logic [2:0]                 stab_trip_out,
    output logic [2:0]                 inst_trip_out,
    output logic [2:0]                 block2_out,
    output logic [2:0]                 block5_out,
    output logic [6*CW-1:0]            rd_chan,
    output logic [ND-1:0]              rd_dig,
    output logic                       rec_busy,
    output logic                       rec_held
);
    // -------------------------------------------------------------------
    // side correction and matching
    // -------------------------------------------------------------------
    logic [CW-1:0] hv_c [3];
    logic [CW-1:0] lv_c [3];
    logic [CW-1:0] hv_ci [3];
    logic [CW-1:0] lv_ci [3];
    logic [CW-1:0] inst_limit;
    logic [2:0]    st_w;
    logic [2:0]    in_w;
    logic [2:0]    b2_w;
    logic [2:0]    b5_w;

    function automatic logic [CW-1:0] corr(input logic [CW-1:0] v, input logic [RW-1:0] k);
        logic [CW+RW-1:0] p;
        p = (CW+RW)'(v) * (CW+RW)'(k);
        corr = CW'(p >> 7);
    endfunction : corr

    // zero-sequence removal on magnitudes: subtract the phase mean (one third of the sum), add half the own phase
    function automatic logic [CW-1:0] zsr(input logic [CW-1:0] a, input logic [CW-1:0] b,
                                          input logic [CW-1:0] c, input logic en);
        logic [CW+1:0] m;
        logic [CW+1:0] third;
        logic [CW+1:0] mn;
        m     = (CW+2)'(a) + (CW+2)'(b) + (CW+2)'(c);
        third = m / (CW+2)'(3);
        mn    = ((CW+2)'(a) < third) ? (CW+2)'(0) : (CW+2)'(a) - third + ((CW+2)'(a) >> 1);
        zsr   = en ? CW'(mn) : a;
    endfunction : zsr

    always_comb begin
        inst_limit = instantaneous_operate_limit;
        if (inst_limit < sdt_pkg::INST_MIN) begin
            inst_limit = sdt_pkg::INST_MIN;
        end else if (inst_limit > sdt_pkg::INST_MAX) begin
            inst_limit = sdt_pkg::INST_MAX;
        end
    end

    logic [CW-1:0] hv_r [3];
    logic [CW-1:0] lv_r [3];

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_corr
            always_comb begin
                hv_r[g]  = corr(hv_fund[g*CW +: CW], hv_ratio_corr);
                lv_r[g]  = corr(lv_fund[g*CW +: CW], lv_ratio_corr);
                hv_ci[g] = corr(hv_inst[g*CW +: CW], hv_ratio_corr);
                lv_ci[g] = corr(lv_inst[g*CW +: CW], lv_ratio_corr);
            end
        end
        for (g = 0; g < 3; g++) begin : g_phase
            logic [CW-1:0] idf;
            logic [CW-1:0] idi;
            logic [CW:0]   stb;
            always_comb begin
                hv_c[g] = zsr(hv_r[g], hv_r[(g+1)%3], hv_r[(g+2)%3], hv_match_en);
                lv_c[g] = zsr(lv_r[g], lv_r[(g+1)%3], lv_r[(g+2)%3], lv_match_en);
                idf = (hv_c[g] > lv_c[g]) ? hv_c[g] - lv_c[g] : lv_c[g] - hv_c[g];
                idi = (hv_ci[g] > lv_ci[g]) ? hv_ci[g] - lv_ci[g] : lv_ci[g] - hv_ci[g];
                // through current: the smaller side, near zero for a fault fed from one side
                stb = (CW+1)'((hv_c[g] < lv_c[g]) ? hv_c[g] : lv_c[g]);
            end
            sdt_phase #(.CW(CW), .RW(RW)) u_phase (
                .id_fund                      (idf),
                .id_inst                      (idi),
                .i_stab                       (CW'(stb)),
                .second_harmonic_ratio        (second_harmonic_ratio[g*RW +: RW]),
                .fifth_harmonic_ratio         (fifth_harmonic_ratio[g*RW +: RW]),
                .internal_fault_hint          (internal_fault_hint[g]),
                .base_level                   (base_level),
                .slope                        (slope),
                .second_limit                 (second_limit),
                .fifth_limit                  (fifth_limit),
                .overexcitation_unblock_limit (overexcitation_unblock_limit),
                .harm_block_disable           (harm_block_disable),
                .inst_limit                   (inst_limit),
                .stab_trip                    (st_w[g]),
                .inst_trip                    (in_w[g]),
                .block2                       (b2_w[g]),
                .block5                       (b5_w[g])
            );
        end
    endgenerate

    // -------------------------------------------------------------------
    // registered decisions
    // -------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            operate       <= 1'b0;
            phase_operate <= '0;
            stab_trip_out <= '0;
            inst_trip_out <= '0;
            block2_out    <= '0;
            block5_out    <= '0;
        end else if (clk_en) begin
            phase_operate <= st_w | in_w;
            operate       <= |(st_w | in_w);
            stab_trip_out <= st_w;
            inst_trip_out <= in_w;
            block2_out    <= b2_w;
            block5_out    <= b5_w;
        end
    end

    AST_OPERATE_OR: assert property (@(posedge sys_clk) disable iff (!rstn)
        clk_en |=> operate == |(phase_operate))
        else $error("operate not OR of phases");
    AST_BLOCK_HARM_DIS: assert property (@(posedge sys_clk) disable iff (!rstn)
        clk_en && harm_block_disable |=> (block2_out == 3'h0) && (block5_out == 3'h0))
        else $error("blocking while disabled");
    AST_INST_CLAMP: assert property (@(posedge sys_clk) disable iff (!rstn)
        inst_limit >= sdt_pkg::INST_MIN && inst_limit <= sdt_pkg::INST_MAX)
        else $error("instantaneous limit out of range");
    AST_PH_OPERATE: assert property (@(posedge sys_clk) disable iff (!rstn)
        clk_en |=> phase_operate == (stab_trip_out | inst_trip_out))
        else $error("phase operate mismatch");
    AST_BLOCK_NO_STAB: assert property (@(posedge sys_clk) disable iff (!rstn)
        ##1 ((stab_trip_out & (block2_out | block5_out)) == 3'h0))
        else $error("stabilized trip while blocked");

    // -------------------------------------------------------------------
    // disturbance recorder
    // -------------------------------------------------------------------
    logic [6*CW-1:0] rec_chan;
    logic [ND-1:0]   rec_dig;
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            rec_chan[i*CW +: CW]     = hv_fund[i*CW +: CW];
            rec_chan[(i+3)*CW +: CW] = lv_fund[i*CW +: CW];
        end
        rec_dig = ND'({control_in, b5_w, b2_w, in_w, st_w});
    end

    sdt_recorder #(.CW(CW), .ND(ND), .AW(AW)) u_rec (
        .sys_clk      (sys_clk),
        .rstn         (rstn),
        .clk_en       (clk_en),
        .sample_tick  (sample_tick),
        .chan_in      (rec_chan),
        .dig_in       (rec_dig),
        .trig_sel     (trig_sel),
        .trig_falling (trig_falling),
        .rec_clear    (rec_clear),
        .rd_addr      (rd_addr),
        .rd_chan      (rd_chan),
        .rd_dig       (rd_dig),
        .rec_busy     (rec_busy),
        .rec_held     (rec_held)
    );
endmodule : sdt_top

// file: verification/sdt_ct_source.sv
// sample pacing model of the current-transformer side
`timescale 1ns/1ps
module sdt_ct_source #(
    parameter int TICK_DIV = 4
) (
    input  wire logic sys_clk,
    input  wire logic rstn,
    output logic      sample_tick
);
    int cnt;
    // ----------------------------------------
    // one sample tick every TICK_DIV clocks
    // ----------------------------------------
    always @(negedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 0;
            sample_tick <= 1'b0;
        end else begin
            cnt <= (cnt == TICK_DIV - 1) ? 0 : cnt + 1;
            sample_tick <= (cnt == 0);
        end
    end
endmodule : sdt_ct_source

// file: verification/sdt_top_tb.sv
// self-checking bench of the differential trip logic
`timescale 1ns/1ps
module sdt_top_tb;
    logic        sys_clk, rstn, clk_en, sample_tick, hv_match_en, lv_match_en;
    logic        harm_block_disable, rec_clear, operate, rec_busy, rec_held;
    logic [47:0] hv_fund, lv_fund, hv_inst, lv_inst;
    logic [23:0] second_harmonic_ratio, fifth_harmonic_ratio;
    logic [7:0]  hv_ratio_corr, lv_ratio_corr, slope, second_limit, fifth_limit;
    logic [7:0]  overexcitation_unblock_limit;
    logic [15:0] base_level, instantaneous_operate_limit, trig_sel, trig_falling, rd_dig;
    logic [4:0]  control_in;
    logic [10:0] rd_addr;
    logic [2:0]  internal_fault_hint, phase_operate, stab_trip_out, inst_trip_out, block2_out, block5_out;
    logic [95:0] rd_chan, keep;
    int          err_total, n_tests, cyc, ticks;

    sdt_top sdt_top_inst (.*);
    sdt_ct_source sdt_ct_source_inst (.sys_clk(sys_clk), .rstn(rstn), .sample_tick(sample_tick));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cyc++;
        if (sample_tick && rec_busy)
            ticks++;
        if (cyc == 20000) begin
            err_total++;
            $display("wrong value run length expected done seen hung");
            give_verdict();
        end
    end

    task automatic chk(input string nm, input logic [95:0] exp, input logic [95:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            err_total++;
        end
    endtask : chk

    task automatic ph1(input logic [15:0] hv, input logic [15:0] lv);
        @(negedge sys_clk);
        hv_fund = {16'h0000, hv, 16'h0000};
        lv_fund = {16'h0000, lv, 16'h0000};
        @(negedge sys_clk);
    endtask : ph1

    task automatic trip(input string nm, input logic [2:0] st, input logic [2:0] it);
        chk({nm, " stab"}, 96'(st), 96'(stab_trip_out));
        chk({nm, " inst"}, 96'(it), 96'(inst_trip_out));
        chk({nm, " phase"}, 96'(st | it), 96'(phase_operate));
        chk({nm, " operate"}, 96'(|(st | it)), 96'(operate));
        $display("test %s done", nm);
    endtask : trip

    task automatic rd(input logic [10:0] a);
        @(negedge sys_clk);
        rd_addr = a;
        @(negedge sys_clk);
    endtask : rd

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict

    initial begin
        {rstn, hv_fund, lv_fund, hv_inst, lv_inst, control_in, rec_clear, rd_addr} = '0;
        {second_harmonic_ratio, fifth_harmonic_ratio, internal_fault_hint, trig_falling} = '0;
        {hv_match_en, lv_match_en, harm_block_disable, err_total, n_tests, cyc, ticks} = '0;
        clk_en = 1'b1;
        hv_ratio_corr = 8'h80;
        lv_ratio_corr = 8'h80;
        base_level = 16'h0064;
        slope = 8'h40;
        second_limit = 8'h28;
        fifth_limit = 8'h28;
        overexcitation_unblock_limit = 8'hc8;
        instantaneous_operate_limit = 16'h07d0;
        trig_sel = 16'h1000;
        repeat (2) @(negedge sys_clk);
        trip("reset", 3'b000, 3'b000);
        rstn = 1'b1;
        ph1(16'h03e8, 16'h0258); trip("stabilized", 3'b010, 3'b000);
        ph1(16'h0960, 16'h07d0); trip("load", 3'b000, 3'b000);
        second_harmonic_ratio = 24'h005000;
        ph1(16'h03e8, 16'h0258); trip("inrush", 3'b000, 3'b000);
        chk("block2", 96'h2, 96'(block2_out));
        internal_fault_hint = 3'b010;
        ph1(16'h03e8, 16'h0258); trip("fault hint", 3'b010, 3'b000);
        {internal_fault_hint, second_harmonic_ratio} = '0;
        fifth_harmonic_ratio = 24'h005000;
        ph1(16'h03e8, 16'h0258); trip("overexc", 3'b000, 3'b000);
        chk("block5", 96'h2, 96'(block5_out));
        fifth_harmonic_ratio = 24'h00dc00;
        ph1(16'h03e8, 16'h0258); trip("unblock", 3'b010, 3'b000);
        {fifth_harmonic_ratio, second_harmonic_ratio, harm_block_disable} = {48'h0050000_05000, 1'b1};
        ph1(16'h03e8, 16'h0258); trip("disable", 3'b010, 3'b000);
        {fifth_harmonic_ratio, second_harmonic_ratio, harm_block_disable} = '0;
        lv_ratio_corr = 8'h40;
        ph1(16'h03e8, 16'h07d0); trip("ratio half", 3'b000, 3'b000);
        lv_ratio_corr = 8'h80;
        ph1(16'h03e8, 16'h07d0); trip("ratio one", 3'b010, 3'b000);
        {hv_match_en, lv_match_en} = 2'b11;
        ph1(16'h03e8, 16'h03e8); trip("matched", 3'b000, 3'b000);
        {hv_match_en, lv_match_en} = 2'b00;
        ph1(16'h0bb8, 16'h0000); trip("inst fund", 3'b010, 3'b010);
        second_harmonic_ratio = 24'h005000;
        ph1(16'h05dc, 16'h0000); trip("low stab", 3'b010, 3'b010);
        chk("low stab block2", 96'h0, 96'(block2_out));
        second_harmonic_ratio = '0;
        instantaneous_operate_limit = 16'h0064;
        ph1(16'h0fa0, 16'h0b54); trip("clamp", 3'b010, 3'b000);
        instantaneous_operate_limit = 16'h07d0;
        hv_inst = 48'h0000_1770_0000;
        ph1(16'h03e8, 16'h03e8); trip("sample over", 3'b000, 3'b010);
        hv_inst = 48'h0000_1324_0000;
        ph1(16'h03e8, 16'h03e8); trip("sample under", 3'b000, 3'b000);
        clk_en = 1'b0;
        ph1(16'h0bb8, 16'h0000); trip("frozen", 3'b000, 3'b000);
        clk_en = 1'b1;
        ph1(16'h03e8, 16'h0258);
        repeat (12) @(negedge sys_clk);
        ticks = 0;
        control_in = 5'h01;
        for (int i = 0; i < 20 && rec_busy !== 1'b1; i++) @(negedge sys_clk);
        chk("busy", 96'h1, 96'(rec_busy));
        for (int i = 0; i < 8000 && rec_held !== 1'b1; i++) @(negedge sys_clk);
        chk("samples", 96'd1520, 96'(ticks));
        chk("held busy", 96'h0, 96'(rec_busy));
        rd(11'h005);
        chk("chan", {lv_fund, hv_fund}, rd_chan);
        chk("dig", 96'h1002, 96'(rd_dig));
        keep = rd_chan;
        $display("test record done");
        control_in = 5'h00;
        ph1(16'h0960, 16'h07d0);
        repeat (4) @(negedge sys_clk);
        control_in = 5'h01;
        repeat (100) @(negedge sys_clk);
        chk("ignored", 96'h1, 96'({rec_busy, rec_held}));
        rd(11'h005); chk("kept", keep, rd_chan);
        trig_falling = 16'h1000;
        rec_clear = 1'b1;
        @(negedge sys_clk);
        rec_clear = 1'b0;
        repeat (12) @(negedge sys_clk);
        control_in = 5'h00;
        for (int i = 0; i < 20 && rec_busy !== 1'b1; i++) @(negedge sys_clk);
        chk("falling", 96'h1, 96'(rec_busy));
        $display("test rerecord done");
        give_verdict();
    end
endmodule : sdt_top_tb
